// *** rtl/pco_ctrl.sv ***
// program control operation executor
// Function
// - conditional alu op writes result only when condition holds
// - flag-updating variant also writes alu status to ccr when true
// - branch on bit zero jumps to pc plus displacement, else steps
// - branch on bit one jumps when tested bit is one, else steps
// - displacement is a 24-bit pc-relative extension word
// - absolute low form reaches x or y locations 0 through 63
// - first short io form reaches FFFFC0 through FFFFFF
// - second short io form reaches FFFF80 through FFFFBF
// - any on-chip register may be the tested source
// - six effective address modes supported for tested operand
// - call on bit zero pushes return and status then jumps
// - call on bit one pushes return and status then jumps
// - lock hits sector or loads 17-bit tag into lru then locks
// - unlock hits sector or loads lru tag leaving it unlocked
// - relative lock forms use pc plus 24-bit signed displacement
// - free-all clears every sector lock only
// - full flush invalidates all, unlocks, resets lru and tags
// - unlocked flush invalidates unlocked only, resets lru
// - unconditional trap starts trap exception processing
// - conditional trap starts exception only when condition holds
// - conditions evaluated from c, z, n, v, e, u, l flags
// assumes op_valid pulses with operands already fetched by the pipeline
`timescale 1ns/1ns
`default_nettype none
module pco_ctrl
  import pco_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              op_valid,
  input  wire pco_op_e           op_code,
  input  wire logic [3:0]        cond_sel,
  input  wire logic [7:0]        ccr_flags,
  input  wire logic [WORD_W-1:0] pc,
  input  wire logic [WORD_W-1:0] ext_word,
  input  wire logic [BITN_W-1:0] bit_num,
  input  wire logic [2:0]        src_form,
  input  wire logic              src_is_y,
  input  wire logic [5:0]        short_addr,
  input  wire logic [2:0]        ea_mode,
  input  wire logic [WORD_W-1:0] addr_reg,
  input  wire logic [WORD_W-1:0] offset_reg,
  input  wire logic [WORD_W-1:0] reg_value,
  input  wire logic [WORD_W-1:0] mem_data,
  input  wire logic [WORD_W-1:0] status_reg,
  input  wire logic [WORD_W-1:0] alu_result,
  input  wire logic [7:0]        alu_flags,
  output logic [WORD_W-1:0]      mem_addr,
  output logic                   mem_is_y,
  output logic [WORD_W-1:0]      addr_reg_new,
  output logic                   addr_reg_we,
  output logic                   alu_write,
  output logic [WORD_W-1:0]      alu_write_data,
  output logic                   ccr_write,
  output logic [7:0]             ccr_write_data,
  output logic                   pc_load,
  output logic [WORD_W-1:0]      pc_value,
  output logic                   stack_push,
  output logic [WORD_W-1:0]      push_return,
  output logic [WORD_W-1:0]      push_status,
  output logic                   pipe_flush,
  output logic                   trap_start,
  output logic [SECT_N-1:0]      sector_locked,
  output logic [SECT_N-1:0]      sector_valid,
  output logic [SECT_W-1:0]      sector_lru
);
  // ******************************************************************
  // helpers
  // ******************************************************************
  // condition test, shared by alu, trap paths
  function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
    logic nv;
    nv = f[F_N] ^ f[F_V];
    case (cc)
      CC_CC:   cond_true = !f[F_C];
      CC_CS:   cond_true = f[F_C];
      CC_EC:   cond_true = !f[F_E];
      CC_ES:   cond_true = f[F_E];
      CC_EQ:   cond_true = f[F_Z];
      CC_NE:   cond_true = !f[F_Z];
      CC_GE:   cond_true = !nv;
      CC_LT:   cond_true = nv;
      CC_GT:   cond_true = !(f[F_Z] | nv);
      CC_LE:   cond_true = f[F_Z] | nv;
      CC_LC:   cond_true = !f[F_L];
      CC_LS:   cond_true = f[F_L];
      CC_MI:   cond_true = f[F_N];
      CC_PL:   cond_true = !f[F_N];
      CC_NR:   cond_true = f[F_Z] | (f[F_U] & f[F_E]);
      CC_NN:   cond_true = !(f[F_Z] | (f[F_U] & f[F_E]));
      default: cond_true = 1'b0;
    endcase
  endfunction

  // pc relative target, wraps in 24 bits
  function automatic logic [WORD_W-1:0] rel_target(input logic [WORD_W-1:0] p,
                                                   input logic [WORD_W-1:0] d);
    rel_target = p + d;
  endfunction

  // ******************************************************************
  // operand address generation
  // ******************************************************************
  logic [WORD_W-1:0] ea_addr, ea_update, short_ext;
  logic              ea_writes;
  logic [WORD_W-1:0] operand, next_mem_addr;
  logic              tested_bit, cc_ok;

  assign short_ext = {18'h0, short_addr & SHORT_MASK};

  // effective address and its register update
  always_comb begin
    ea_addr   = addr_reg;
    ea_update = addr_reg;
    ea_writes = 1'b0;
    case (ea_mode)
      EA_POSTDEC_N: begin
        ea_update = addr_reg - offset_reg;
        ea_writes = 1'b1;
      end
      EA_POSTINC_N: begin
        ea_update = addr_reg + offset_reg;
        ea_writes = 1'b1;
      end
      EA_POSTINC: begin
        ea_update = addr_reg + PC_STEP;
        ea_writes = 1'b1;
      end
      EA_INDEXED: ea_addr = addr_reg + offset_reg;
      EA_PREDEC: begin
        ea_addr   = addr_reg - PC_STEP;
        ea_update = addr_reg - PC_STEP;
        ea_writes = 1'b1;
      end
      default: ea_addr = addr_reg; // register indirect
    endcase
  end

  // address presented to x or y memory for the tested operand
  always_comb begin
    case (src_form)
      FORM_ABS: next_mem_addr = ABS_BASE | short_ext;
      FORM_IOP: next_mem_addr = IOP_BASE | short_ext;
      FORM_IOQ: next_mem_addr = IOQ_BASE | short_ext;
      default:  next_mem_addr = ea_addr;
    endcase
  end
  assign mem_addr = next_mem_addr;
  assign mem_is_y = src_is_y;

  // register source bypasses memory; bit numbers above 23 read zero
  assign operand    = (src_form == FORM_REG) ? reg_value : mem_data;
  assign tested_bit = (bit_num <= BIT_MAX) ? operand[bit_num] : 1'b0;
  assign cc_ok      = cond_true(cond_sel, ccr_flags);

  // ******************************************************************
  // execute decisions
  // ******************************************************************
  logic is_bit_op, is_call, jump, want_one;
  logic [WORD_W-1:0] lock_addr;
  logic n_alu_w, n_ccr_w, n_pc_ld, n_push, n_flush, n_trap, n_arw;
  logic [WORD_W-1:0] n_pc, n_ret;

  always_comb begin
    is_bit_op = op_code inside {OP_BRZ, OP_BRO, OP_CALLZ, OP_CALLO};
    is_call   = op_code inside {OP_CALLZ, OP_CALLO};
    want_one  = op_code inside {OP_BRO, OP_CALLO};
    jump      = op_valid && is_bit_op && (tested_bit == want_one);
    n_alu_w   = op_valid && (op_code inside {OP_IF, OP_IFU}) && cc_ok;
    n_ccr_w   = op_valid && (op_code == OP_IFU) && cc_ok;
    n_push    = jump && is_call;
    n_pc_ld   = op_valid && is_bit_op;
    n_ret     = pc + PC_STEP + PC_STEP;
    n_pc      = jump ? rel_target(pc, ext_word) : pc + PC_STEP + PC_STEP;
    n_flush   = jump;
    n_trap    = op_valid && ((op_code == OP_TRAP) ||
                ((op_code == OP_TRAPC) && cc_ok));
    n_arw     = op_valid && is_bit_op && ea_writes && (src_form == FORM_EA);
    lock_addr = (op_code inside {OP_LOCKR, OP_UNLR}) ?
                rel_target(pc, ext_word) : ea_addr;
  end

  // cache maintenance state
  pco_cache_ctl u_cache (
    .clock       (clock),
    .rst_n       (rst_n),
    .do_lock     (op_valid && (op_code inside {OP_LOCKA, OP_LOCKR})),
    .do_unlock   (op_valid && (op_code inside {OP_UNLA, OP_UNLR})),
    .do_free     (op_valid && (op_code == OP_FREE)),
    .do_flush    (op_valid && (op_code == OP_FLUSH)),
    .do_flush_un (op_valid && (op_code == OP_FLUN)),
    .addr        (lock_addr),
    .lock_state  (sector_locked),
    .valid_state (sector_valid),
    .lru_sector  (sector_lru)
  );

  // ******************************************************************
  // registered results, one cycle after op_valid
  // ******************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alu_write      <= 1'b0;
      alu_write_data <= '0;
      ccr_write      <= 1'b0;
      ccr_write_data <= '0;
      pc_load        <= 1'b0;
      pc_value       <= '0;
      stack_push     <= 1'b0;
      push_return    <= '0;
      push_status    <= '0;
      pipe_flush     <= 1'b0;
      trap_start     <= 1'b0;
      addr_reg_we    <= 1'b0;
      addr_reg_new   <= '0;
    end else begin
      alu_write      <= n_alu_w;
      alu_write_data <= alu_result;
      ccr_write      <= n_ccr_w;
      ccr_write_data <= alu_flags;
      pc_load        <= n_pc_ld;
      pc_value       <= n_pc;
      stack_push     <= n_push;
      push_return    <= n_ret;
      push_status    <= status_reg;
      pipe_flush     <= n_flush;
      trap_start     <= n_trap;
      addr_reg_we    <= n_arw;
      addr_reg_new   <= ea_update;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  property p_alu_only_true;
    @(posedge clock) disable iff (!rst_n)
      op_valid && (op_code == OP_IF) |=> alu_write == $past(cc_ok) && !ccr_write;
  endproperty
  a_alu_only_true: assert property (p_alu_only_true) else $error("alu write mismatch");

  property p_ccr_update;
    @(posedge clock) disable iff (!rst_n)
      op_valid && (op_code == OP_IFU) |=> ccr_write == alu_write;
  endproperty
  a_ccr_update: assert property (p_ccr_update) else $error("ccr update mismatch");

  sequence s_taken_jump;
    op_valid && is_bit_op && (tested_bit == want_one);
  endsequence
  property p_jump_target;
    @(posedge clock) disable iff (!rst_n)
      s_taken_jump |=> pc_load && pc_value == $past(pc) + $past(ext_word) && pipe_flush;
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

  property p_no_jump_steps;
    @(posedge clock) disable iff (!rst_n)
      op_valid && op_code == OP_BRO && !tested_bit |=> !pipe_flush && !stack_push;
  endproperty
  a_no_jump_steps: assert property (p_no_jump_steps) else $error("untaken branch jumped");

  property p_call_push;
    @(posedge clock) disable iff (!rst_n)
      op_valid && op_code == OP_CALLZ && !tested_bit |=>
        stack_push && push_return == $past(pc) + 24'h000002;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call did not push");

  property p_push_only_call;
    @(posedge clock) disable iff (!rst_n)
      stack_push |-> pipe_flush && pc_load;
  endproperty
  a_push_only_call: assert property (p_push_only_call) else $error("push without jump");

  property p_io_range;
    @(posedge clock) disable iff (!rst_n)
      src_form == FORM_IOP |-> mem_addr[23:6] == 18'h3FFFF;
  endproperty
  a_io_range: assert property (p_io_range) else $error("io address out of range");

  property p_trap;
    @(posedge clock) disable iff (!rst_n)
      op_valid && op_code == OP_TRAP |=> trap_start;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not started");

  property p_free;
    @(posedge clock) disable iff (!rst_n)
      op_valid && op_code == OP_FREE |=> sector_locked == '0 && $stable(sector_valid);
  endproperty
  a_free: assert property (p_free) else $error("free left locks");
endmodule
`default_nettype wire

// *** rtl/pco_pkg.sv ***
// package for the program control operation block
// assumes one core clock and a decoder that presents one op at a time
package pco_pkg;
  // ******************************************************************
  // widths and opcodes
  // ******************************************************************
  localparam int WORD_W  = 24;
  localparam int TAG_W   = 17;
  localparam int SECT_N  = 8;
  localparam int SECT_W  = 3;
  localparam int BITN_W  = 5;
  localparam logic [4:0] BIT_MAX = 5'h17;

  // address forms of the tested operand
  localparam logic [2:0] FORM_EA  = 3'h0;
  localparam logic [2:0] FORM_ABS = 3'h1;
  localparam logic [2:0] FORM_IOP = 3'h2;
  localparam logic [2:0] FORM_IOQ = 3'h3;
  localparam logic [2:0] FORM_REG = 3'h4;
  localparam logic [23:0] IOP_BASE = 24'hFFFFC0;
  localparam logic [23:0] IOQ_BASE = 24'hFFFF80;
  localparam logic [23:0] ABS_BASE = 24'h000000;
  localparam logic [5:0]  SHORT_MASK = 6'h3F;

  // effective address modes
  localparam logic [2:0] EA_POSTDEC_N = 3'h0;
  localparam logic [2:0] EA_POSTINC_N = 3'h1;
  localparam logic [2:0] EA_INDIRECT  = 3'h2;
  localparam logic [2:0] EA_POSTINC   = 3'h3;
  localparam logic [2:0] EA_INDEXED   = 3'h4;
  localparam logic [2:0] EA_PREDEC    = 3'h5;

  typedef enum logic [3:0] {
    OP_NONE  = 4'h0, OP_IF    = 4'h1, OP_IFU   = 4'h2, OP_BRZ  = 4'h3,
    OP_BRO   = 4'h4, OP_CALLZ = 4'h5, OP_CALLO = 4'h6, OP_LOCKA= 4'h7,
    OP_UNLA  = 4'h8, OP_LOCKR = 4'h9, OP_UNLR  = 4'hA, OP_FREE = 4'hB,
    OP_FLUSH = 4'hC, OP_FLUN  = 4'hD, OP_TRAP  = 4'hE, OP_TRAPC= 4'hF
  } pco_op_e;

  // condition codes
  localparam logic [3:0] CC_CC = 4'h0, CC_GE = 4'h1, CC_NE = 4'h2, CC_PL = 4'h3;
  localparam logic [3:0] CC_NN = 4'h4, CC_EC = 4'h5, CC_LC = 4'h6, CC_GT = 4'h7;
  localparam logic [3:0] CC_CS = 4'h8, CC_LT = 4'h9, CC_EQ = 4'hA, CC_MI = 4'hB;
  localparam logic [3:0] CC_NR = 4'hC, CC_ES = 4'hD, CC_LS = 4'hE, CC_LE = 4'hF;
  // status flag positions within the condition code byte
  localparam int F_C = 0, F_V = 1, F_Z = 2, F_N = 3, F_U = 4, F_E = 5, F_L = 6;
  localparam logic [23:0] PC_STEP = 24'h000001;
endpackage

// *** rtl/pco_cache_ctl.sv ***
// sector lock, tag and lru state of the instruction cache
// assumes one maintenance command per cycle from the control block
`timescale 1ns/1ns
`default_nettype none
module pco_cache_ctl
  import pco_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              do_lock,
  input  wire logic              do_unlock,
  input  wire logic              do_free,
  input  wire logic              do_flush,
  input  wire logic              do_flush_un,
  input  wire logic [WORD_W-1:0] addr,
  output logic [SECT_N-1:0]      lock_state,
  output logic [SECT_N-1:0]      valid_state,
  output logic [SECT_W-1:0]      lru_sector
);
  // ******************************************************************
  // state
  // ******************************************************************
  logic [TAG_W-1:0]  tag [SECT_N];
  logic [TAG_W-1:0]  next_tag [SECT_N];
  logic [SECT_N-1:0] lock, next_lock, valid, next_valid;
  logic [SECT_W-1:0] age [SECT_N];
  logic [SECT_W-1:0] next_age [SECT_N];
  logic [TAG_W-1:0]  want;
  logic              hit;
  logic [SECT_W-1:0] hit_idx, victim, used;

  assign want        = addr[WORD_W-1 -: TAG_W];
  assign lock_state  = lock;
  assign valid_state = valid;
  assign lru_sector  = victim;

  // tag match and oldest sector search
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    victim  = '0;
    for (int i = 0; i < SECT_N; i++) begin
      if (valid[i] && tag[i] == want) begin
        hit     = 1'b1;
        hit_idx = SECT_W'(i);
      end
      if (age[i] == SECT_W'(SECT_N-1)) victim = SECT_W'(i);
    end
  end

  // next values; default lru is identity order, default tag is zero
  always_comb begin
    next_lock  = lock;
    next_valid = valid;
    used       = hit ? hit_idx : victim;
    for (int i = 0; i < SECT_N; i++) begin
      next_tag[i] = tag[i];
      next_age[i] = age[i];
    end
    if (do_lock || do_unlock) begin
      if (!hit) begin
        next_tag[victim]   = want;
        next_valid[victim] = 1'b1;
      end
      next_lock[used] = do_lock;
      for (int i = 0; i < SECT_N; i++)
        if (age[i] < age[used]) next_age[i] = age[i] + SECT_W'(1);
      next_age[used] = '0;
    end else if (do_free) begin
      next_lock = '0;
    end else if (do_flush) begin
      next_lock  = '0;
      next_valid = '0;
      for (int i = 0; i < SECT_N; i++) begin
        next_tag[i] = '0;
        next_age[i] = SECT_W'(i);
      end
    end else if (do_flush_un) begin
      for (int i = 0; i < SECT_N; i++) begin
        next_age[i] = SECT_W'(i);
        if (!lock[i]) begin
          next_tag[i]   = '0;
          next_valid[i] = 1'b0;
        end
      end
    end
  end

  // registers only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock  <= '0;
      valid <= '0;
      for (int i = 0; i < SECT_N; i++) begin
        tag[i] <= '0;
        age[i] <= SECT_W'(i);
      end
    end else begin
      lock  <= next_lock;
      valid <= next_valid;
      tag   <= next_tag;
      age   <= next_age;
    end
  end
endmodule
`default_nettype wire

// *** verif/pco_mem_model.sv ***
// memory model answering the tested-operand reads of the control block
// assumes a combinational read, sampled by the block in the same cycle
`timescale 1ns/1ns
`default_nettype none
module pco_mem_model
  import pco_pkg::*;
(
  input  wire logic [WORD_W-1:0] mem_addr,
  input  wire logic              mem_is_y,
  output logic [WORD_W-1:0]      mem_data
);
  // ******************************************************************
  // read path
  // ******************************************************************
  // address-keyed pattern, so a wrong address or space flips tested bits
  assign mem_data = mem_addr ^ (mem_is_y ? 24'hA5C35A : 24'h3C6996);
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the program control operation block
// assumes pco_ctrl with its cache block and the memory model compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pco_pkg::*;
;
  // ******************************************************************
  // signals
  // ******************************************************************
  logic              clock, rst_n, op_valid, src_is_y;
  pco_op_e           op_code;
  logic [3:0]        cond_sel;
  logic [7:0]        ccr_flags, alu_flags, ccr_write_data, e_cwd, e_lock;
  logic [BITN_W-1:0] bit_num;
  logic [2:0]        src_form, ea_mode;
  logic [5:0]        short_addr;
  logic [WORD_W-1:0] pc, ext_word, addr_reg, offset_reg, reg_value, mem_data, status_reg;
  logic [WORD_W-1:0] alu_result, mem_addr, addr_reg_new, alu_write_data, pc_value;
  logic [WORD_W-1:0] push_return, push_status, e_pcv, e_ret, e_st, e_new, e_awd;
  logic              mem_is_y, addr_reg_we, alu_write, ccr_write, pc_load, stack_push;
  logic              pipe_flush, trap_start, chk_br, chk_alu, chk_trap, chk_c;
  logic              e_fl, e_push, e_we, e_aw, e_cw, e_trap;
  logic [SECT_N-1:0] sector_locked, sector_valid;
  logic [SECT_W-1:0] sector_lru;
  logic [3:0]        e_lru;
  int                error_cnt, comparisons, cycles, seed;
  pco_op_e           ops [8] = '{OP_IF, OP_IFU, OP_BRZ, OP_BRO, OP_CALLZ, OP_CALLO,
                                 OP_TRAP, OP_TRAPC};

  pco_ctrl dut (.clock(clock), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .cond_sel(cond_sel), .ccr_flags(ccr_flags), .pc(pc), .ext_word(ext_word),
    .bit_num(bit_num), .src_form(src_form), .src_is_y(src_is_y), .short_addr(short_addr),
    .ea_mode(ea_mode), .addr_reg(addr_reg), .offset_reg(offset_reg), .reg_value(reg_value),
    .mem_data(mem_data), .status_reg(status_reg), .alu_result(alu_result),
    .alu_flags(alu_flags), .mem_addr(mem_addr), .mem_is_y(mem_is_y),
    .addr_reg_new(addr_reg_new), .addr_reg_we(addr_reg_we), .alu_write(alu_write),
    .alu_write_data(alu_write_data), .ccr_write(ccr_write), .ccr_write_data(ccr_write_data),
    .pc_load(pc_load), .pc_value(pc_value), .stack_push(stack_push),
    .push_return(push_return), .push_status(push_status), .pipe_flush(pipe_flush),
    .trap_start(trap_start), .sector_locked(sector_locked), .sector_valid(sector_valid),
    .sector_lru(sector_lru));
  pco_mem_model mem (.mem_addr(mem_addr), .mem_is_y(mem_is_y), .mem_data(mem_data));

  // ******************************************************************
  // clock, timeout and reporting
  // ******************************************************************
  // free-running core clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ******************************************************************
  // expectation functions
  // ******************************************************************
  // upper codes are the plain test, lower codes its complement
  function automatic logic cond_ok(input logic [3:0] s, input logic [7:0] f);
    logic b;
    case (s[2:0])
      3'h0: b = f[F_C];
      3'h1: b = f[F_N] ^ f[F_V];
      3'h2: b = f[F_Z];
      3'h3: b = f[F_N];
      3'h4: b = f[F_Z] | (f[F_U] & f[F_E]);
      3'h5: b = f[F_E];
      3'h6: b = f[F_L];
      default: b = f[F_Z] | (f[F_N] ^ f[F_V]);
    endcase
    return s[3] ? b : ~b;
  endfunction
  function automatic logic [23:0] src_addr();
    case (src_form)
      FORM_ABS: return ABS_BASE | {18'h0, short_addr};
      FORM_IOP: return IOP_BASE | {18'h0, short_addr};
      FORM_IOQ: return IOQ_BASE | {18'h0, short_addr};
      default: return (ea_mode == EA_INDEXED) ? addr_reg + offset_reg :
                      (ea_mode == EA_PREDEC) ? addr_reg - 24'h1 : addr_reg;
    endcase
  endfunction

  // ******************************************************************
  // per-cycle driving and checking
  // ******************************************************************
  // registered answers of the previous op are judged as the next op goes in
  task automatic step();
    @(posedge clock);
    #1;
    if (chk_br) begin
      check("pc_load", pc_load, 1'b1);
      check("pc_value", pc_value, e_pcv);
      check("pipe_flush", pipe_flush, e_fl);
      check("stack_push", stack_push, e_push);
      if (e_push) check("push_return", push_return, e_ret);
      if (e_push) check("push_status", push_status, e_st);
      check("addr_reg_we", addr_reg_we, e_we);
      if (e_we) check("addr_reg_new", addr_reg_new, e_new);
    end
    if (chk_alu) begin
      check("alu_write", alu_write, e_aw);
      if (e_aw) check("alu_write_data", alu_write_data, e_awd);
      check("ccr_write", ccr_write, e_cw);
      if (e_cw) check("ccr_write_data", ccr_write_data, e_cwd);
    end
    if (chk_trap) check("trap_start", trap_start, e_trap);
    if (chk_alu || chk_trap || chk_c) check("pc_load", pc_load, 1'b0);
    if (chk_br || chk_trap || chk_c) check("alu_write", alu_write, 1'b0);
    if (chk_br || chk_alu || chk_c) check("trap_start", trap_start, 1'b0);
    if (chk_c) check("sector_locked", sector_locked, e_lock);
    if (chk_c && !e_lru[3]) check("sector_lru", sector_lru, e_lru[2:0]);
    {chk_br, chk_alu, chk_trap, chk_c} = 4'h0;
    e_lru = 4'h8;
    op_valid = 1'b1;
  endtask
  // work out what the op now on the inputs must produce
  task automatic expect_op();
    logic [23:0] a, w;
    logic        b, t;
    a = src_addr();
    #1;
    case (op_code)
      OP_IF, OP_IFU: begin
        t = cond_ok(cond_sel, ccr_flags);
        chk_alu = 1'b1;
        e_aw = t;
        e_awd = alu_result;
        e_cw = t & (op_code == OP_IFU);
        e_cwd = alu_flags;
      end
      OP_TRAP, OP_TRAPC: begin
        chk_trap = 1'b1;
        e_trap = (op_code == OP_TRAP) | cond_ok(cond_sel, ccr_flags);
      end
      OP_BRZ, OP_BRO, OP_CALLZ, OP_CALLO: begin
        if (src_form != FORM_REG) check("mem_addr", mem_addr, a);
        if (src_form != FORM_REG) check("mem_is_y", mem_is_y, src_is_y);
        w = (src_form == FORM_REG) ? reg_value : a ^ (src_is_y ? 24'hA5C35A : 24'h3C6996);
        b = (bit_num <= BIT_MAX) ? w[bit_num] : 1'b0;
        t = (op_code == OP_BRZ || op_code == OP_CALLZ) ? ~b : b;
        chk_br = 1'b1;
        e_fl = t;
        e_pcv = t ? pc + ext_word : pc + 24'h2;
        e_push = t & (op_code == OP_CALLZ || op_code == OP_CALLO);
        e_ret = pc + 24'h2;
        e_st = status_reg;
        e_we = (src_form == FORM_EA) && ea_mode != EA_INDIRECT && ea_mode != EA_INDEXED;
        e_new = (ea_mode == EA_POSTDEC_N) ? addr_reg - offset_reg :
                (ea_mode == EA_POSTINC_N) ? addr_reg + offset_reg :
                (ea_mode == EA_POSTINC) ? addr_reg + 24'h1 : addr_reg - 24'h1;
      end
      default: ;
    endcase
  endtask
  // cache op; absolute and relative forms both resolve to address a
  task automatic cop(input pco_op_e o, input logic [23:0] a, input logic [7:0] l,
                     input logic [3:0] r);
    step();
    op_code = o;
    src_form = FORM_EA;
    ea_mode = EA_INDIRECT;
    addr_reg = a;
    pc = a - 24'h000100;
    ext_word = 24'h000100;
    chk_c = 1'b1;
    e_lock = l;
    e_lru = r;
  endtask

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    seed = 20;
    error_cnt = 0;
    comparisons = 0;
    cycles = 0;
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = OP_NONE;
    {cond_sel, ccr_flags, alu_flags, bit_num, src_form, src_is_y, short_addr, ea_mode} = '0;
    {pc, ext_word, addr_reg, offset_reg, reg_value, status_reg, alu_result} = '0;
    {chk_br, chk_alu, chk_trap, chk_c} = 4'h0;
    e_lru = 4'h8;
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    check("sector_locked", sector_locked, 8'h00);
    check("sector_lru", sector_lru, 3'h7);
    // random mix of conditional, branch, call and trap ops, back to back
    for (int i = 0; i < 300; i++) begin
      step();
      op_code = ops[{$random(seed)} % 8];
      {cond_sel, ccr_flags, bit_num} = $random(seed);
      {src_is_y, short_addr, alu_flags} = $random(seed);
      src_form = {$random(seed)} % 5;
      ea_mode = {$random(seed)} % 6;
      {pc, ext_word, addr_reg} = {$random(seed), $random(seed), $random(seed)};
      {offset_reg, reg_value, status_reg} = {$random(seed), $random(seed), $random(seed)};
      alu_result = $random(seed);
      expect_op();
    end
    // bit boundaries: top bit set, first out-of-range bit tests as zero
    for (int i = 0; i < 4; i++) begin
      step();
      op_code = i[0] ? OP_CALLO : OP_BRO;
      src_form = FORM_REG;
      reg_value = i[1] ? 24'hFFFFFF : 24'h800000;
      bit_num = i[1] ? 5'h18 : BIT_MAX;
      expect_op();
    end
    // lock by miss and hit, unlock, free keeps tags, flushes
    cop(OP_LOCKA, 24'h123400, 8'h80, 4'h6);
    cop(OP_LOCKR, 24'h123405, 8'h80, 4'h6);
    cop(OP_LOCKR, 24'h010000, 8'hC0, 4'h5);
    cop(OP_UNLA, 24'h123400, 8'h40, 4'h8);
    cop(OP_UNLR, 24'h7F0000, 8'h40, 4'h8);
    cop(OP_LOCKA, 24'h123400, 8'hC0, 4'h8);
    cop(OP_FREE, 24'h000000, 8'h00, 4'h8);
    cop(OP_LOCKA, 24'h123400, 8'h80, 4'h8);
    check("sector_valid", sector_valid, 8'hE0);
    cop(OP_FLUN, 24'h000000, 8'h80, 4'h7);
    cop(OP_LOCKA, 24'h123400, 8'h80, 4'h6);
    check("sector_valid", sector_valid, 8'h80);
    cop(OP_FLUSH, 24'h000000, 8'h00, 4'h7);
    step();
    op_code = OP_NONE;
    check("sector_valid", sector_valid, 8'h00);
    step();
    op_valid = 1'b0;
    stop_test();
  end
endmodule
`default_nettype wire
